// File: apw_pkg.sv
// Constants, register map and carrier types of the PIO sector write block.
// Assumes a 32-bit APB master and a media writer on the same clock.
package apw_pkg;

  // ==========================================================================
  // Register map (byte addresses)
  localparam logic [7:0] OFS_DATA = 8'h00;
  localparam logic [7:0] OFS_ERROR = 8'h04;
  localparam logic [7:0] OFS_SECCNT = 8'h08;
  localparam logic [7:0] OFS_SECNUM = 8'h0c;
  localparam logic [7:0] OFS_CYLLO = 8'h10;
  localparam logic [7:0] OFS_CYLHI = 8'h14;
  localparam logic [7:0] OFS_DEVHEAD = 8'h18;
  localparam logic [7:0] OFS_CMDSTAT = 8'h1c;
  localparam logic [7:0] OFS_DEVCTL = 8'h20;
  localparam logic [7:0] OFS_BLKSIZE = 8'h24;
  localparam logic [7:0] OFS_IRQSTAT = 8'h28;
  localparam logic [7:0] OFS_IRQMASK = 8'h2c;

  // ==========================================================================
  // Commands and field positions
  localparam logic [7:0] OP_WR_MULT_FUA = 8'hce;
  localparam logic [6:0] OP_WR_SECT_HI = 7'h18;
  localparam int DEVCTL_HOB_BIT = 7;
  localparam int DEVHEAD_LBA_BIT = 6;
  localparam int ERR_IDN_BIT = 4;
  localparam int ERR_ABT_BIT = 2;
  localparam int IRQ_BLOCK_BIT = 0;
  localparam int IRQ_DONE_BIT = 1;
  localparam int IRQ_FAIL_BIT = 2;

  // ==========================================================================
  // Counts, geometry and reset values
  localparam logic [7:0] LAST_WORD = 8'hff;
  localparam logic [16:0] EXT_ZERO_COUNT = 17'h10000;
  localparam logic [16:0] STD_ZERO_COUNT = 17'h00100;
  localparam logic [7:0] GEOM_SPT = 8'h3f;
  localparam logic [3:0] GEOM_HEAD_LAST = 4'hf;
  localparam logic [15:0] GEOM_CYL_LAST = 16'h3fff;
  localparam logic [47:0] MAX_LBA = 48'h0000_0fff_ffff;
  localparam logic [7:0] DEVHEAD_RST = 8'ha0;
  localparam logic [7:0] BLKSIZE_RST = 8'h00;
  localparam logic [2:0] IRQMASK_RST = 3'h0;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {ST_IDLE, ST_RECV, ST_STREAM, ST_WAIT} apwFsm_t;

  typedef struct packed {
    logic [7:0] secCntCur;
    logic [7:0] secCntPrev;
    logic [7:0] secNumCur;
    logic [7:0] secNumPrev;
    logic [7:0] cylLoCur;
    logic [7:0] cylLoPrev;
    logic [7:0] cylHiCur;
    logic [7:0] cylHiPrev;
    logic [7:0] devHead;
  } apwTaskfile_t;

  // Media writer request: one 16-bit word per valid/ready handshake
  typedef struct packed {
    logic valid;
    logic [15:0] data;
    logic [47:0] addr;
    logic chs;
  } apwMediaReq_t;

  // Media writer answer: done pulses once the sector is on the media
  typedef struct packed {
    logic ready;
    logic done;
    logic fail;
  } apwMediaRsp_t;

  typedef struct packed {
    apwFsm_t fsm;
    apwTaskfile_t tf;
    logic [7:0] errFlags;
    logic errBit;
    logic hob;
    logic [7:0] blkSize;
    logic [2:0] irqStat;
    logic [2:0] irqMask;
    logic irqOut;
    logic isExt;
    logic chs;
    logic [16:0] remain;
    logic [7:0] blkLeft;
    logic [47:0] curAddr;
    logic [47:0] lastAddr;
    logic [7:0] wordIdx;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    apwMediaReq_t media;
  } apwState_t;

endpackage

// File: apw_sector_write.sv
// Device-side engine for the FUA multiple write and the single-sector-irq write.
// Assumes an APB master for the taskfile and a media writer answering per sector.
//
// Behaviour
// [RQ1] Opcode ceh starts the 48-bit forced-unit-access multiple write.
// [RQ2] FUA write posts ending status only after the media confirms the data.
// [RQ3] FUA write interrupts once per block of the programmed block size.
// [RQ4] Sector data arrives through the data register as 16-bit words.
// [RQ5] 48-bit count is previous:current bytes; zero means 65,536 sectors.
// [RQ6] 48-bit address: current bytes give bits 23:0, previous bytes bits 47:24.
// [RQ7] On 48-bit failure report failing address; HOB selects upper or lower bytes.
// [RQ8] Opcodes 30h and 31h both start the single-sector write.
// [RQ9] 28-bit count is one byte; zero means 256 sectors.
// [RQ10] Address-mode bit clear: sector, 16-bit cylinder and head address the sector.
// [RQ11] Address-mode bit set: 28-bit block address from the four taskfile fields.
// [RQ12] An uncorrectable error stops the command at the failing sector.
// [RQ13] 28-bit write leaves the count of sectors not transferred.
// [RQ14] 28-bit write leaves the last transferred sector address, in its mode.
// [RQ15] Each sector is received from the host first, then written to media.
// [RQ16] Error byte flags only not-found and aborted; status busy/fault/corrected clear.
`timescale 1ns/100ps
module apw_sector_write
  import apw_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt
  output logic irq,
  // Media writer
  output apw_pkg::apwMediaReq_t mediaReq,
  input wire apw_pkg::apwMediaRsp_t mediaRsp
);

  import apw_pkg::*;

  // ==========================================================================
  // Reset release
  logic rstMeta_q;
  logic rstSync_q;

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rstMeta_q <= 1'b0;
      rstSync_q <= 1'b0;
    end
    else
    begin
      rstMeta_q <= 1'b1;
      rstSync_q <= rstMeta_q;
    end
  end

  // ==========================================================================
  // Address helpers
  function automatic logic [47:0] nextAddr(input logic [47:0] a, input logic chs);
    logic [47:0] n;
    n = a;
    if (!chs)
      n = a + 48'h1;
    else if (a[7:0] >= GEOM_SPT)
    begin
      n[7:0] = 8'h01;
      if (a[27:24] == GEOM_HEAD_LAST)
      begin
        n[27:24] = 4'h0;
        n[23:8] = a[23:8] + 16'h1;
      end
      else
        n[27:24] = a[27:24] + 4'h1;
    end
    else
      n[7:0] = a[7:0] + 8'h1; // [RQ10]
    return n;
  endfunction

  function automatic logic addrBad(input logic [47:0] a, input logic chs);
    logic bad;
    bad = 1'b0;
    if (chs)
      bad = (a[7:0] == 8'h00) || (a[7:0] > GEOM_SPT) || (a[23:8] > GEOM_CYL_LAST);
    else
      bad = a > MAX_LBA;
    return bad;
  endfunction

  // ==========================================================================
  // Sector buffer
  // One sector only: the host cannot run ahead of the media, which keeps the
  // FUA ordering trivially correct at the cost of throughput.
  logic [15:0] secBuf [0:255];
  apwState_t q;
  apwState_t d;
  logic dataWr;

  always_ff @(posedge sys_clk)
  begin
    if (dataWr)
      secBuf[q.wordIdx] <= pwdata[15:0]; // [RQ4]
  end

  // ==========================================================================
  // Next state
  always_comb
  begin
    logic apwSetup;
    logic apwDone;
    logic wr;
    logic idle;
    logic busy;
    logic mapped;
    logic [31:0] rd;
    logic [7:0] status;
    logic [2:0] irqSet;
    logic [2:0] irqClr;
    logic finish;
    logic fail;
    logic [7:0] failFlags;
    logic [47:0] repAddr;
    logic [47:0] nAddr;
    logic [15:0] cnt16;
    apwSetup = 1'b0;
    apwDone = 1'b0;
    wr = 1'b0;
    idle = 1'b0;
    busy = 1'b0;
    mapped = 1'b0;
    rd = 32'h0;
    status = 8'h00;
    irqSet = 3'h0;
    irqClr = 3'h0;
    finish = 1'b0;
    fail = 1'b0;
    failFlags = 8'h00;
    repAddr = 48'h0;
    nAddr = 48'h0;
    cnt16 = 16'h0;
    dataWr = 1'b0;
    d = q;

    idle = q.fsm == ST_IDLE;
    busy = (q.fsm == ST_STREAM) || (q.fsm == ST_WAIT);
    status = {busy, 1'b1, 1'b0, 1'b1, q.fsm == ST_RECV, 1'b0, 1'b0, q.errBit}; // [RQ16]

    // APB: one wait state, so read data comes straight from a flip-flop
    apwSetup = psel && penable && !q.pready;
    apwDone = psel && penable && q.pready;
    wr = apwDone && pwrite;

    unique case (paddr)
      OFS_DATA: mapped = 1'b1;
      OFS_ERROR: rd[7:0] = q.errFlags;
      OFS_SECCNT: rd[7:0] = q.hob ? q.tf.secCntPrev : q.tf.secCntCur;
      OFS_SECNUM: rd[7:0] = q.hob ? q.tf.secNumPrev : q.tf.secNumCur; // [RQ7]
      OFS_CYLLO: rd[7:0] = q.hob ? q.tf.cylLoPrev : q.tf.cylLoCur; // [RQ7]
      OFS_CYLHI: rd[7:0] = q.hob ? q.tf.cylHiPrev : q.tf.cylHiCur; // [RQ7]
      OFS_DEVHEAD: rd[7:0] = q.tf.devHead;
      OFS_CMDSTAT: rd[7:0] = status;
      OFS_DEVCTL: rd[DEVCTL_HOB_BIT] = q.hob;
      OFS_BLKSIZE: rd[7:0] = q.blkSize;
      OFS_IRQSTAT: rd[2:0] = q.irqStat;
      OFS_IRQMASK: rd[2:0] = q.irqMask;
      default: mapped = 1'b0;
    endcase
    mapped = mapped || (paddr[7:2] <= OFS_IRQMASK[7:2] && paddr[1:0] == 2'b00);

    d.pready = apwSetup;
    d.pslverr = apwSetup && !mapped;
    d.prdata = (apwSetup && mapped && !pwrite) ? rd : 32'h0;

    // Register writes; the taskfile is frozen while a command runs
    if (wr && idle)
    begin
      unique case (paddr)
        OFS_SECCNT:
        begin
          d.tf.secCntPrev = q.tf.secCntCur;
          d.tf.secCntCur = pwdata[7:0];
          d.hob = 1'b0;
        end
        OFS_SECNUM:
        begin
          d.tf.secNumPrev = q.tf.secNumCur;
          d.tf.secNumCur = pwdata[7:0];
          d.hob = 1'b0;
        end
        OFS_CYLLO:
        begin
          d.tf.cylLoPrev = q.tf.cylLoCur;
          d.tf.cylLoCur = pwdata[7:0];
          d.hob = 1'b0;
        end
        OFS_CYLHI:
        begin
          d.tf.cylHiPrev = q.tf.cylHiCur;
          d.tf.cylHiCur = pwdata[7:0];
          d.hob = 1'b0;
        end
        OFS_DEVHEAD: d.tf.devHead = pwdata[7:0];
        OFS_BLKSIZE: d.blkSize = pwdata[7:0];
        default: d.hob = d.hob;
      endcase
    end
    if (wr && paddr == OFS_DEVCTL)
      d.hob = pwdata[DEVCTL_HOB_BIT];
    if (wr && paddr == OFS_IRQMASK)
      d.irqMask = pwdata[2:0];
    if (wr && paddr == OFS_IRQSTAT)
      irqClr = pwdata[2:0];

    // Command decode
    if (wr && idle && paddr == OFS_CMDSTAT)
    begin
      d.errFlags = 8'h00;
      d.errBit = 1'b0;
      d.wordIdx = 8'h00;
      cnt16 = {q.tf.secCntPrev, q.tf.secCntCur};
      if (pwdata[7:0] == OP_WR_MULT_FUA) // [RQ1]
      begin
        d.isExt = 1'b1;
        d.chs = 1'b0;
        d.remain = (cnt16 == 16'h0) ? EXT_ZERO_COUNT : {1'b0, cnt16}; // [RQ5]
        d.curAddr = {q.tf.cylHiPrev, q.tf.cylLoPrev, q.tf.secNumPrev,
                     q.tf.cylHiCur, q.tf.cylLoCur, q.tf.secNumCur}; // [RQ6]
        d.blkLeft = q.blkSize; // [RQ3]
      end
      else if (pwdata[7:1] == OP_WR_SECT_HI) // [RQ8]
      begin
        d.isExt = 1'b0;
        d.chs = !q.tf.devHead[DEVHEAD_LBA_BIT];
        d.remain = (q.tf.secCntCur == 8'h0) ? STD_ZERO_COUNT : {9'h0, q.tf.secCntCur}; // [RQ9]
        d.curAddr = {20'h0, q.tf.devHead[3:0], q.tf.cylHiCur,
                     q.tf.cylLoCur, q.tf.secNumCur}; // [RQ10] [RQ11]
        d.blkLeft = 8'h01;
      end
      d.lastAddr = d.curAddr;
      if (pwdata[7:0] != OP_WR_MULT_FUA && pwdata[7:1] != OP_WR_SECT_HI)
      begin
        finish = 1'b1;
        fail = 1'b1;
        failFlags[ERR_ABT_BIT] = 1'b1;
        d.isExt = 1'b1;
        d.lastAddr = d.curAddr;
      end
      else if (pwdata[7:0] == OP_WR_MULT_FUA && q.blkSize == 8'h00)
      begin
        finish = 1'b1;
        fail = 1'b1;
        failFlags[ERR_ABT_BIT] = 1'b1;
      end
      else if (addrBad(d.curAddr, d.chs))
      begin
        finish = 1'b1;
        fail = 1'b1;
        failFlags[ERR_IDN_BIT] = 1'b1;
      end
      else
        d.fsm = ST_RECV;
    end

    // Sector engine
    unique case (q.fsm)
      ST_IDLE:
        d.media.valid = 1'b0;
      ST_RECV:
      begin
        if (wr && paddr == OFS_DATA)
        begin
          dataWr = 1'b1; // [RQ4]
          d.wordIdx = q.wordIdx + 8'h1;
          if (q.wordIdx == LAST_WORD)
          begin
            // Whole sector buffered before any media traffic
            d.fsm = ST_STREAM; // [RQ15]
            d.media.valid = 1'b1;
            d.media.data = secBuf[0];
            d.media.addr = q.curAddr;
            d.media.chs = q.chs;
          end
        end
      end
      ST_STREAM:
      begin
        if (mediaRsp.ready)
        begin
          d.wordIdx = q.wordIdx + 8'h1;
          d.media.data = secBuf[d.wordIdx];
          if (q.wordIdx == LAST_WORD)
          begin
            d.media.valid = 1'b0;
            d.fsm = ST_WAIT;
          end
        end
      end
      ST_WAIT:
      begin
        if (mediaRsp.done)
        begin
          nAddr = nextAddr(q.curAddr, q.chs);
          if (mediaRsp.fail)
          begin
            // Stop here; curAddr still names the failing sector
            finish = 1'b1; // [RQ12]
            fail = 1'b1;
            failFlags[ERR_ABT_BIT] = 1'b1; // [RQ16]
          end
          else
          begin
            d.lastAddr = q.curAddr;
            d.remain = q.remain - 17'h1;
            d.curAddr = nAddr;
            if (q.remain == 17'h1)
              finish = 1'b1; // [RQ2]
            else if (addrBad(nAddr, q.chs))
            begin
              finish = 1'b1;
              fail = 1'b1;
              failFlags[ERR_IDN_BIT] = 1'b1;
            end
            else
            begin
              d.fsm = ST_RECV;
              d.blkLeft = q.blkLeft - 8'h1;
              if (q.blkLeft == 8'h01)
              begin
                irqSet[IRQ_BLOCK_BIT] = 1'b1; // [RQ3]
                d.blkLeft = q.isExt ? q.blkSize : 8'h01;
              end
            end
          end
        end
      end
    endcase

    // Ending status and reported taskfile
    if (finish)
    begin
      d.fsm = ST_IDLE;
      d.media.valid = 1'b0;
      d.errFlags = failFlags; // [RQ16]
      d.errBit = fail;
      irqSet[IRQ_DONE_BIT] = 1'b1;
      irqSet[IRQ_FAIL_BIT] = fail;
      // Decode-time aborts must report in the form of the new command, not the last one
      repAddr = (d.isExt && fail) ? d.curAddr : d.lastAddr; // [RQ7]
      d.tf.secNumCur = repAddr[7:0];
      d.tf.cylLoCur = repAddr[15:8];
      d.tf.cylHiCur = repAddr[23:16];
      if (d.isExt)
      begin
        d.tf.secNumPrev = repAddr[31:24];
        d.tf.cylLoPrev = repAddr[39:32];
        d.tf.cylHiPrev = repAddr[47:40];
      end
      else
      begin
        d.tf.devHead[3:0] = repAddr[27:24]; // [RQ14]
        d.tf.secCntCur = d.remain[7:0]; // [RQ13]
      end
    end

    // Set wins over a same-cycle clear
    d.irqStat = (q.irqStat & ~irqClr) | irqSet;
    d.irqOut = |(d.irqStat & d.irqMask);
  end

  // ==========================================================================
  // State register
  always_ff @(posedge sys_clk or negedge rstSync_q)
  begin
    if (!rstSync_q)
    begin
      q <= '0;
      q.fsm <= ST_IDLE;
      q.tf.devHead <= DEVHEAD_RST;
      q.blkSize <= BLKSIZE_RST;
      q.irqMask <= IRQMASK_RST;
    end
    else
      q <= d;
  end

  // ==========================================================================
  // Outputs
  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign irq = q.irqOut;
  assign mediaReq = q.media;

endmodule

// File: apw_sector_write_assertions.sv
// Port-level checks of the PIO sector write engine.
// Assumes one clock domain; bound to the engine at the foot of this file.
`timescale 1ns/100ps
module apw_sector_write_assertions
  import apw_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Interrupt and media
  input wire logic irq,
  input wire apw_pkg::apwMediaReq_t mediaReq,
  input wire apw_pkg::apwMediaRsp_t mediaRsp
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  logic [7:0] taken;
  logic pend;
  logic rdSt;
  logic dataWr;
  assign rdSt = pready && !pwrite && paddr == OFS_CMDSTAT;
  assign dataWr = pready && pwrite && paddr == OFS_DATA;
  // ======
  // Words per sector, and a sector waiting for its commit
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      taken <= 8'h00;
      pend <= 1'b0;
    end
    else
    begin
      if (mediaReq.valid && mediaRsp.ready)
        taken <= taken + 8'h01;
      if (mediaRsp.done)
        pend <= 1'b0;
      else if (mediaReq.valid && mediaRsp.ready && taken == 8'hff)
        pend <= 1'b1;
    end
  end
  // ======
  // Assertions
  a_ready_wait: assert property (psel && penable && $past(psel && !penable) |-> !pready ##1 pready)
    else $error("pready not one cycle after the first access cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_slverr_map: assert property (pready |-> pslverr == (paddr > OFS_IRQMASK))
    else $error("pslverr does not match the address map");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero outside pready");
  a_word_hold: assert property (mediaReq.valid && !mediaRsp.ready |=>
    mediaReq.valid && $stable(mediaReq.data) && $stable(mediaReq.addr))
    else $error("media word changed before acceptance");
  a_sector_words: assert property ($fell(mediaReq.valid) |-> taken == 8'h00)
    else $error("sector not 256 words");
  a_valid_start: assert property ($rose(mediaReq.valid) |-> $past(dataWr) || $past(dataWr, 2))
    else $error("media write before host data");
  a_commit_first: assert property (rdSt && pend |-> !prdata[3])
    else $error("data request before media commit");
  a_status_clean: assert property (rdSt |-> (prdata & 32'hffffff24) == 32'h0)
    else $error("fault or corrected bit set in status");
  a_error_only: assert property (pready && !pwrite && paddr == OFS_ERROR |->
    (prdata & 32'hffffffeb) == 32'h0)
    else $error("error byte flags outside not-found and aborted");
endmodule

bind apw_sector_write apw_sector_write_assertions u_apw_sector_write_assertions (.sys_clk, .resetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq, .mediaReq, .mediaRsp);

// File: apw_media_model.sv
// Media writer model: takes 16-bit words and commits each sector after a delay.
// Assumes the bench chooses the pace and the sector that fails.
`timescale 1ns/100ps
module apw_media_model
  import apw_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Media port
  input wire apw_pkg::apwMediaReq_t mediaReq,
  output apw_pkg::apwMediaRsp_t mediaRsp,
  // Bench side
  input wire logic slow,
  input wire logic [15:0] failIdx,
  output logic [15:0] secCount,
  output logic [47:0] lastAddr,
  output logic [15:0] wordErr
);
  logic [8:0] words;
  logic [4:0] delay;
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      mediaRsp <= '0;
      words <= '0;
      delay <= '0;
      secCount <= '0;
      lastAddr <= '0;
      wordErr <= '0;
    end
    else
    begin
      // Slow pace drops ready every other cycle
      mediaRsp.ready <= !slow || !mediaRsp.ready;
      mediaRsp.done <= 1'b0;
      mediaRsp.fail <= 1'b0;
      if (mediaReq.valid && mediaRsp.ready)
      begin
        wordErr <= wordErr + 16'(mediaReq.data[7:0] != words[7:0]);
        lastAddr <= mediaReq.addr;
        words <= words + 9'h001;
        if (words == 9'h0ff)
          delay <= slow ? 5'h14 : 5'h01;
      end
      // Commit only once the whole sector is in
      if (delay == 5'h01)
      begin
        mediaRsp.done <= 1'b1;
        mediaRsp.fail <= secCount == failIdx;
        secCount <= secCount + 16'h0001;
        words <= '0;
      end
      if (delay != 5'h00)
        delay <= delay - 5'h01;
    end
  end
endmodule

// File: apw_sector_write_tb.sv
// Bench for the PIO sector write engine: APB host tasks and command scenarios.
// Assumes the media model, the checker and its bind compile with it.
`timescale 1ns/100ps
module apw_sector_write_tb;
  import apw_pkg::*;
  logic sys_clk, resetn, psel, penable, pwrite, pready, pslverr, irq, slow, ok, slvErr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [15:0] failIdx, secCount, wordErr, base;
  logic [47:0] lastAddr;
  apwMediaReq_t mediaReq;
  apwMediaRsp_t mediaRsp;
  int fail_count, cmp_count;
  logic [7:0] bad [2] = '{8'h55, OP_WR_MULT_FUA};

  apw_sector_write u_apw_sector_write (.sys_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .irq, .mediaReq, .mediaRsp);
  apw_media_model u_apw_media_model (.sys_clk, .resetn, .mediaReq, .mediaRsp, .slow, .failIdx,
    .secCount, .lastAddr, .wordErr);

  // ======
  // Host tasks
  task automatic chk(input string n, input logic [47:0] e, input logic [47:0] g);
    cmp_count++;
    if (g !== e)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  // No cycle count assumed: only the watchdog ends a wait for pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1)
      @(posedge sys_clk);
    r = prdata;
    slvErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, 48'(e), 48'(r));
  endtask
  task automatic tf(input logic [7:0] sc, sn, cl, ch, dh);
    apb(1'b1, OFS_SECCNT, 32'(sc));
    apb(1'b1, OFS_SECNUM, 32'(sn));
    apb(1'b1, OFS_CYLLO, 32'(cl));
    apb(1'b1, OFS_CYLHI, 32'(ch));
    apb(1'b1, OFS_DEVHEAD, 32'(dh));
  endtask
  // Polls bounded; an error status ends the wait too
  task automatic waitDrq();
    int n;
    n = 0;
    r = 0;
    while (r[3] !== 1'b1 && r[0] !== 1'b1 && n < 500)
    begin
      apb(1'b0, OFS_CMDSTAT, 32'h0);
      n++;
    end
    ok = r[3];
  endtask
  task automatic xfer(input int n);
    for (int s = 0; s < n; s++)
    begin
      waitDrq();
      if (ok !== 1'b1)
        break;
      for (int w = 0; w < 256; w++)
        apb(1'b1, OFS_DATA, {16'h0, 8'(s), 8'(w)});
    end
  endtask
  task automatic ends(input logic [2:0] e);
    int n;
    n = 0;
    r = 0;
    while (r[2:1] == 2'b00 && n < 500)
    begin
      apb(1'b0, OFS_IRQSTAT, 32'h0);
      n++;
    end
    chk("irqStat", 48'(e), 48'(r[2:0]));
    chk("irq", 48'h1, 48'(irq));
    apb(1'b1, OFS_IRQMASK, 32'h0);
    rdchk("irqMask", OFS_IRQMASK, 32'h0);
    chk("irqMasked", 48'h0, 48'(irq));
    apb(1'b1, OFS_IRQMASK, 32'h7);
    apb(1'b1, OFS_IRQSTAT, 32'h7);
    rdchk("irqClear", OFS_IRQSTAT, 32'h0);
    chk("irqLow", 48'h0, 48'(irq));
  endtask
  task automatic give_verdict();
    $display("Comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ======
  // Clock, watchdog and scenarios
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  initial
  begin
    #1200000;
    fail_count++;
    give_verdict();
  end
  initial
  begin
    {resetn, psel, penable, pwrite, paddr, pwdata, slow, fail_count, cmp_count} = '0;
    failIdx = 16'hffff;
    repeat (20) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rdchk("status", OFS_CMDSTAT, 32'h50);
    chk("mappedErr", 48'h0, 48'(slvErr));
    rdchk("error", OFS_ERROR, 32'h0);
    rdchk("devHead", OFS_DEVHEAD, 32'ha0);
    rdchk("unmapped", 8'h30, 32'h0);
    chk("slvErr", 48'h1, 48'(slvErr));
    apb(1'b1, OFS_IRQMASK, 32'h7);
    // Unknown opcode, and block mode with no block size, both abort: done and failed both set
    foreach (bad[i])
    begin
      apb(1'b1, OFS_CMDSTAT, 32'(bad[i]));
      ends(3'h6);
      rdchk("abort", OFS_ERROR, 32'h4);
    end
    // Block address, two sectors, slow media; every sector but the last raises a block request
    slow <= 1'b1;
    tf(8'h02, 8'hfe, 8'h12, 8'h34, 8'he5);
    apb(1'b1, OFS_CMDSTAT, 32'h30);
    xfer(2);
    ends(3'h3);
    chk("lbaAddr", 48'h0000_0534_12ff, lastAddr);
    chk("lbaMode", 48'h0, 48'(mediaReq.chs));
    rdchk("leftCnt", OFS_SECCNT, 32'h0);
    rdchk("lastSec", OFS_SECNUM, 32'hff);
    rdchk("lastCylLo", OFS_CYLLO, 32'h12);
    rdchk("lastCylHi", OFS_CYLHI, 32'h34);
    apb(1'b0, OFS_DEVHEAD, 32'h0);
    chk("lastHead", 48'h5, 48'(r[3:0]));
    rdchk("doneStat", OFS_CMDSTAT, 32'h50);
    // Cylinder address, second of three sectors fails
    slow <= 1'b0;
    base = secCount;
    failIdx <= secCount + 16'h1;
    tf(8'h03, 8'h05, 8'h02, 8'h01, 8'ha3);
    apb(1'b1, OFS_CMDSTAT, 32'h31);
    xfer(3);
    ends(3'h7);
    chk("chsAddr", 48'h0000_0301_0206, lastAddr);
    chk("chsMode", 48'h1, 48'(mediaReq.chs));
    chk("chsSectors", 48'h2, 48'(secCount - base));
    rdchk("chsLeft", OFS_SECCNT, 32'h2);
    rdchk("chsErr", OFS_ERROR, 32'h4);
    rdchk("chsStat", OFS_CMDSTAT, 32'h51);
    // Sector number past the geometry
    tf(8'h01, 8'h40, 8'h00, 8'h00, 8'ha0);
    apb(1'b1, OFS_CMDSTAT, 32'h30);
    xfer(1);
    ends(3'h6);
    rdchk("notFound", OFS_ERROR, 32'h10);
    // Block mode, blocks of two, third sector fails after one block request
    apb(1'b1, OFS_BLKSIZE, 32'h2);
    base = secCount;
    failIdx <= secCount + 16'h2;
    tf(8'h00, 8'h01, 8'h00, 8'h00, 8'h40);
    tf(8'h03, 8'h10, 8'h20, 8'h30, 8'h40);
    apb(1'b1, OFS_CMDSTAT, 32'(OP_WR_MULT_FUA));
    xfer(1);
    waitDrq();
    rdchk("midBlock", OFS_IRQSTAT, 32'h0);
    xfer(2);
    ends(3'h7);
    chk("extAddr", 48'h0000_0130_2012, lastAddr);
    chk("extSectors", 48'h3, 48'(secCount - base));
    rdchk("extErr", OFS_ERROR, 32'h4);
    rdchk("failLo0", OFS_SECNUM, 32'h12);
    rdchk("failLo1", OFS_CYLLO, 32'h20);
    rdchk("failLo2", OFS_CYLHI, 32'h30);
    apb(1'b1, OFS_DEVCTL, 32'h80);
    rdchk("failHi0", OFS_SECNUM, 32'h01);
    rdchk("failHi1", OFS_CYLLO, 32'h00);
    rdchk("failHi2", OFS_CYLHI, 32'h00);
    chk("wordOrder", 48'h0, 48'(wordErr));
    give_verdict();
  end
endmodule
